// >>> rtl/watch_supervisor_pkg.sv
// Shared constants for the password-protected watchdog and interval timer.
package watch_supervisor_pkg;

    // ------------------------------------------------------------------
    // Register map and access keys
    // ------------------------------------------------------------------
    localparam logic [15:0] SUPERVISOR_CONTROL_ADDR = 16'h0120;
    localparam logic [7:0]  WRITE_KEY               = 8'h5A;
    localparam logic [7:0]  READ_SIGNATURE          = 8'h69;
    localparam logic [7:0]  CONTROL_RESET           = 8'h00;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int INTERVAL_SEL_LO_BIT      = 0;
    localparam int INTERVAL_SEL_HI_BIT      = 1;
    localparam int CLOCK_SELECT_BIT         = 2;
    localparam int COUNTER_CLEAR_BIT        = 3;
    localparam int INTERVAL_MODE_SELECT_BIT = 4;
    localparam int PIN_FUNCTION_BIT         = 5;
    localparam int PIN_EDGE_SELECT_BIT      = 6;
    localparam int HOLD_BIT                 = 7;

    // ------------------------------------------------------------------
    // Interval tap codes and the counter bit each one watches
    // ------------------------------------------------------------------
    localparam logic [1:0] TAP_CODE_LONGEST = 2'b00;
    localparam logic [1:0] TAP_CODE_LONG    = 2'b01;
    localparam logic [1:0] TAP_CODE_SHORT   = 2'b10;
    localparam logic [1:0] TAP_CODE_SHORTEST = 2'b11;
    localparam logic [3:0] TAP_BIT_LONGEST  = 4'hF;
    localparam logic [3:0] TAP_BIT_LONG     = 4'hD;
    localparam logic [3:0] TAP_BIT_SHORT    = 4'h9;
    localparam logic [3:0] TAP_BIT_SHORTEST = 4'h6;

    // Depth of the pin synchroniser.
    localparam int PIN_SYNC_STAGES = 3;

endpackage : watch_supervisor_pkg

// >>> rtl/watch_supervisor.sv
// Watchdog and interval timer with a password-protected control word.
// Overview of operation
// RULE1: Hidden 16-bit counter, reached only via control.
// RULE2: Two low bits pick one of four taps.
// RULE3: Bit 2 selects main or auxiliary clock.
// RULE4: Writing bit 3 restarts counter; reads undefined.
// RULE5: Bit 4 selects watchdog or interval mode.
// RULE6: Bit 5: pin level reset or edge interrupt.
// RULE7: Bit 6 selects rising or falling pin edge.
// RULE8: Changing edge select may fire the interrupt.
// RULE9: Bit 7 holds the counter at its value.
// RULE10: Reads need no key; high byte constant.
// RULE11: Writes update only with correct key byte.
// RULE12: Wrong key on write forces system reset.
// RULE13: Software uses whole 16-bit word accesses only.
// RULE14: Watchdog expiry or key violation resets system.
// RULE15: Flag marks resets caused by this block.
// RULE16: Any reset clears control bits and counter.
// RULE17: Interval mode sets flag every elapsed interval.
// RULE18: Interrupt needs flag, enable and global enable.
// RULE19: Servicing clears flag, leaves enable unchanged.
// RULE20: Interval vector differs from the reset vector.
// RULE21: Software changes interval together with counter clear.
// RULE22: Software holds counter before switching clock source.
// RULE23: Expiry is the tap bit's rising edge, one pulse.
module watch_supervisor
    import watch_supervisor_pkg::*;
#(
    parameter int CounterWidth = 16
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        systemResetIn,
    input  wire logic        auxClkTick,
    input  wire logic [15:0] perAddr,
    input  wire logic        perRdEn,
    input  wire logic        perWrEn,
    input  wire logic [15:0] perWrData,
    output logic      [15:0] perRdData,
    input  wire logic        rstNmiPin,
    input  wire logic        supervisorIrqEnable,
    input  wire logic        globalIrqEnable,
    input  wire logic        irqServiced,
    input  wire logic        flagClear,
    output logic             supervisorFlag,
    output logic             irqRequest,
    output logic             intervalVectorSel,
    output logic             systemResetReq,
    output logic             pinResetActive,
    output logic             nmiPulse
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The longest tap is fixed at bit 15, so the counter must be 16 bits.
    if (CounterWidth != 16)
    begin : g_width_check
        $error("watch_supervisor supports only a 16-bit counter");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]              control_q;
    logic [CounterWidth-1:0] counter_q;
    logic [CounterWidth-1:0] counter_d;
    logic                    tapPrev_q;
    logic                    tapBit;
    logic [3:0]              tapIndex;
    logic                    countTick;
    logic                    expiryPulse;
    logic                    ctrlHit;
    logic                    keyOk;
    logic                    goodWrite;
    logic                    keyViolation;
    logic                    clearRequest;
    logic                    watchdogExpiry;
    logic                    ownReset;
    logic                    anyReset;
    logic                    systemResetReq_q;
    logic                    supervisorFlag_q;
    logic [15:0]             perRdData_q;
    logic [PIN_SYNC_STAGES-1:0] pinSync_q;
    logic                    pinStable_q;
    logic                    edgeView;
    logic                    edgeViewPrev_q;
    logic                    nmiPulse_q;

    // Field views of the control byte.
    logic [1:0] intervalSel;
    logic       clockSelect;
    logic       intervalMode;
    logic       pinIsNmi;
    logic       pinEdgeSelect;
    logic       holdCounter;

    assign intervalSel   = control_q[INTERVAL_SEL_HI_BIT:INTERVAL_SEL_LO_BIT];
    assign clockSelect   = control_q[CLOCK_SELECT_BIT];
    assign intervalMode  = control_q[INTERVAL_MODE_SELECT_BIT];
    assign pinIsNmi      = control_q[PIN_FUNCTION_BIT];
    assign pinEdgeSelect = control_q[PIN_EDGE_SELECT_BIT];
    assign holdCounter   = control_q[HOLD_BIT];

    // ------------------------------------------------------------------
    // Control word access decode
    // ------------------------------------------------------------------
    // Only full-word writes are expected; the key byte is checked on every one.
    assign ctrlHit      = (perAddr == SUPERVISOR_CONTROL_ADDR);
    assign keyOk        = (perWrData[15:8] == WRITE_KEY);
    assign goodWrite    = perWrEn & ctrlHit & keyOk;              // [RULE11] [RULE13]
    assign keyViolation = perWrEn & ctrlHit & ~keyOk;             // [RULE12]
    assign clearRequest = goodWrite & perWrData[COUNTER_CLEAR_BIT]; // [RULE4]

    // A system reset from outside or one raised here both clear the control byte, counter and tap edge.
    assign ownReset = systemResetReq_q;
    assign anyReset = rst | systemResetIn | ownReset;

    // Control byte: the clear bit is a command and is never stored.
    always_ff @(posedge core_clk)
    begin
        if (anyReset)
        begin
            control_q <= CONTROL_RESET;                             // [RULE16] [RULE14]
        end
        else if (goodWrite)
        begin
            control_q <= perWrData[7:0] & ~(8'h01 << COUNTER_CLEAR_BIT); // [RULE11]
        end
    end

    // Read data needs no key; the high byte is a fixed signature.
    always_ff @(posedge core_clk)
    begin
        if (!rst && perRdEn && ctrlHit)
        begin
            perRdData_q <= {READ_SIGNATURE, control_q};             // [RULE10]
        end
        else
        begin
            perRdData_q <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Counter clocking and interval taps
    // ------------------------------------------------------------------
    // The auxiliary clock arrives as an enable pulse on core_clk, so the
    // clock multiplexer is a choice of enable; hold gates both sources.
    assign countTick = ~holdCounter & (clockSelect ? auxClkTick : 1'b1); // [RULE3] [RULE9]

    always_comb
    begin
        unique case (intervalSel)                                   // [RULE2]
            TAP_CODE_SHORTEST: tapIndex = TAP_BIT_SHORTEST;
            TAP_CODE_SHORT:    tapIndex = TAP_BIT_SHORT;
            TAP_CODE_LONG:     tapIndex = TAP_BIT_LONG;
            TAP_CODE_LONGEST:  tapIndex = TAP_BIT_LONGEST;
        endcase
    end

    assign tapBit = counter_q[tapIndex];

    // Counter next value: clear beats counting, hold freezes it.
    always_comb
    begin
        if (clearRequest)
        begin
            counter_d = '0;                                         // [RULE4] [RULE17]
        end
        else if (countTick)
        begin
            counter_d = counter_q + 1'b1;
        end
        else
        begin
            counter_d = counter_q;                                  // [RULE9]
        end
    end

    // The counter has no bus path of its own; software cannot see it.
    always_ff @(posedge core_clk)
    begin
        if (anyReset)
        begin
            counter_q <= '0;                                        // [RULE1] [RULE16]
        end
        else
        begin
            counter_q <= counter_d;
        end
    end

    // Expiry is the rising edge of the chosen tap. Changing the tap without
    // a clear can show an instant edge, which is the known hazard.
    always_ff @(posedge core_clk)
    begin
        if (anyReset)
        begin
            tapPrev_q <= 1'b0;
        end
        else
        begin
            tapPrev_q <= tapBit;
        end
    end

    assign expiryPulse    = tapBit & ~tapPrev_q;                    // [RULE23]
    assign watchdogExpiry = expiryPulse & ~intervalMode;            // [RULE5]

    // ------------------------------------------------------------------
    // System reset request and supervisor flag
    // ------------------------------------------------------------------
    // One-cycle reset request; it also clears this block's own state.
    always_ff @(posedge core_clk)
    begin
        if (rst || systemResetIn)
        begin
            systemResetReq_q <= 1'b0;
        end
        else
        begin
            systemResetReq_q <= (watchdogExpiry | keyViolation) & ~ownReset; // [RULE14] [RULE12]
        end
    end

    // Flag survives the system reset it causes; only power-on clears it
    // besides software and servicing. A new event wins over a clear.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            supervisorFlag_q <= 1'b0;
        end
        else if ((watchdogExpiry | keyViolation) & ~ownReset)
        begin
            supervisorFlag_q <= 1'b1;                               // [RULE15]
        end
        else if (expiryPulse & intervalMode & ~ownReset)
        begin
            supervisorFlag_q <= 1'b1;                               // [RULE17]
        end
        else if (flagClear || (irqServiced && intervalMode))
        begin
            supervisorFlag_q <= 1'b0;                               // [RULE19]
        end
    end

    // Enable bit lives outside and is never touched by servicing.
    assign irqRequest = supervisorFlag_q & intervalMode
                        & supervisorIrqEnable & globalIrqEnable;    // [RULE18] [RULE19]
    assign intervalVectorSel = intervalMode;                        // [RULE20]

    // ------------------------------------------------------------------
    // Reset / interrupt pin
    // ------------------------------------------------------------------
    // Three-stage synchroniser; a level is accepted once stages two and
    // three agree, which filters a single-cycle glitch.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pinSync_q   <= '1;
            pinStable_q <= 1'b1;
        end
        else
        begin
            pinSync_q <= {pinSync_q[PIN_SYNC_STAGES-2:0], rstNmiPin};
            if (pinSync_q[1] == pinSync_q[2])
            begin
                pinStable_q <= pinSync_q[2];
            end
        end
    end

    // Edge select inverts the pin ahead of a rising detector, so flipping
    // the select can itself look like an edge.
    assign edgeView = pinStable_q ^ pinEdgeSelect;                  // [RULE7] [RULE8]

    // The previous view resets to the idle view, so reset never fakes an edge.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            edgeViewPrev_q <= 1'b1;
            nmiPulse_q     <= 1'b0;
        end
        else
        begin
            edgeViewPrev_q <= edgeView;
            nmiPulse_q     <= pinIsNmi & edgeView & ~edgeViewPrev_q; // [RULE6] [RULE8]
        end
    end

    // Level-sensitive reset while the pin is low in reset function.
    assign pinResetActive = ~pinIsNmi & ~pinStable_q;               // [RULE6]

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign perRdData      = perRdData_q;
    assign supervisorFlag = supervisorFlag_q;
    assign systemResetReq = systemResetReq_q;
    assign nmiPulse       = nmiPulse_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_bad_key_reset: assert property (                              // [RULE12]
        keyViolation && !systemResetIn && !ownReset |=> systemResetReq)
        else $error("Wrong key did not raise system reset.");

    a_good_key_update: assert property (                            // [RULE11]
        goodWrite && !systemResetIn && !ownReset
        |=> control_q == ($past(perWrData[7:0]) & 8'hF7))
        else $error("Keyed write did not update control.");

    a_reset_clears_ctrl: assert property (                          // [RULE16]
        systemResetReq |=> control_q == 8'h00 && counter_q == '0)
        else $error("Own reset did not clear control and counter.");

    a_read_signature: assert property (                             // [RULE10]
        perRdEn && ctrlHit |=> perRdData[15:8] == 8'h69
                                && perRdData[7:0] == $past(control_q))
        else $error("Read word has wrong contents.");

    a_hold_freezes: assert property (                               // [RULE9]
        holdCounter && !clearRequest && !anyReset |=> $stable(counter_q))
        else $error("Counter moved while held.");

    a_clear_restarts: assert property (                             // [RULE4]
        clearRequest && !anyReset |=> counter_q == '0)
        else $error("Counter clear did not restart counter.");

    a_expiry_single: assert property (                              // [RULE23]
        expiryPulse |=> !expiryPulse)
        else $error("Expiry pulse longer than one cycle.");

    a_watchdog_expiry: assert property (                            // [RULE14]
        watchdogExpiry && !systemResetIn && !ownReset
        |=> systemResetReq && supervisorFlag)
        else $error("Watchdog expiry missed reset or flag.");

    a_interval_flag: assert property (                              // [RULE17]
        expiryPulse && intervalMode && !ownReset |=> supervisorFlag && !systemResetReq)
        else $error("Interval expiry did not set flag.");

    a_irq_gating: assert property (                                 // [RULE18]
        irqRequest |-> supervisorFlag && supervisorIrqEnable
                       && globalIrqEnable && intervalMode)
        else $error("Interrupt raised without all enables.");

    a_pin_reset_level: assert property (                            // [RULE6]
        !pinIsNmi && !pinStable_q |-> pinResetActive && !nmiPulse)
        else $error("Pin reset function misbehaves.");

    a_count_main_clock: assert property (                           // [RULE3]
        !clockSelect && !holdCounter && !clearRequest && !anyReset
        |=> counter_q == $past(counter_q) + 16'h0001)
        else $error("Counter missed a main-clock step.");

endmodule // watch_supervisor

// >>> dv/watch_supervisor_tb.sv
// Self-checking testbench for the password-protected watchdog and interval timer.
`define CHECK(got, exp) \
    begin \
        checkCount++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module watch_supervisor_tb
    import watch_supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk;
    logic        rst;
    logic        systemResetIn;
    logic        auxClkTick;
    logic [15:0] perAddr;
    logic        perRdEn;
    logic        perWrEn;
    logic [15:0] perWrData;
    logic [15:0] perRdData;
    logic        rstNmiPin;
    logic        supervisorIrqEnable;
    logic        globalIrqEnable;
    logic        irqServiced;
    logic        flagClear;
    logic        supervisorFlag;
    logic        irqRequest;
    logic        intervalVectorSel;
    logic        systemResetReq;
    logic        pinResetActive;
    logic        nmiPulse;
    int          failures;
    int          checkCount;
    int          n;
    logic [15:0] rdData;

    watch_supervisor #(.CounterWidth(16)) i_watch_supervisor (
        .core_clk            (core_clk),
        .rst                 (rst),
        .systemResetIn       (systemResetIn),
        .auxClkTick          (auxClkTick),
        .perAddr             (perAddr),
        .perRdEn             (perRdEn),
        .perWrEn             (perWrEn),
        .perWrData           (perWrData),
        .perRdData           (perRdData),
        .rstNmiPin           (rstNmiPin),
        .supervisorIrqEnable (supervisorIrqEnable),
        .globalIrqEnable     (globalIrqEnable),
        .irqServiced         (irqServiced),
        .flagClear           (flagClear),
        .supervisorFlag      (supervisorFlag),
        .irqRequest          (irqRequest),
        .intervalVectorSel   (intervalVectorSel),
        .systemResetReq      (systemResetReq),
        .pinResetActive      (pinResetActive),
        .nmiPulse            (nmiPulse)
    );

    // ------------------------------------------------------------------
    // Clocks and the cut-off for a hang
    // ------------------------------------------------------------------
    // The 200 MHz core clock, 5 ns period.
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // The auxiliary clock is a one-cycle enable every fourth core cycle.
    initial
    begin
        auxClkTick = 1'b0;
        forever
        begin
            repeat (3) @(posedge core_clk);
            #1 auxClkTick = 1'b1;
            @(posedge core_clk);
            #1 auxClkTick = 1'b0;
        end
    end

    // The tests take about 43000 cycles, mostly the longest tap; 60000 leaves margin.
    initial
    begin
        #300000;
        failures++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    // A word write, strobe held for exactly one taking edge.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1 perAddr = a;
        perWrData = d;
        perWrEn = 1'b1;
        @(posedge core_clk);
        #1 perWrEn = 1'b0;
    endtask

    // A word read; the data stands for the one cycle after the taking edge.
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1 perAddr = a;
        perRdEn = 1'b1;
        @(posedge core_clk);
        #1 perRdEn = 1'b0;
        d = perRdData;
    endtask

    // Bounded waits, so a dead counter cannot stall the run.
    task automatic wait_flag(input int lim, output int c);
        c = 0;
        while (supervisorFlag !== 1'b1 && c < lim)
        begin
            @(posedge core_clk);
            #1 c++;
        end
    endtask

    task automatic wait_reset(input int lim, output int c);
        c = 0;
        while (systemResetReq !== 1'b1 && c < lim)
        begin
            @(posedge core_clk);
            #1 c++;
        end
    endtask

    // Counts interrupt pulses seen over the given number of cycles.
    task automatic count_nmi(input int cyc, output int c);
        c = 0;
        repeat (cyc)
        begin
            @(posedge core_clk);
            #1 if (nmiPulse === 1'b1) c++;
        end
    endtask

    // Single-cycle pulse on the software flag clear.
    task automatic clear_flag();
        @(posedge core_clk);
        #1 flagClear = 1'b1;
        @(posedge core_clk);
        #1 flagClear = 1'b0;
    endtask

    task automatic give_verdict();
        if (failures == 0 && checkCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        failures = 0;
        checkCount = 0;
        rst = 1'b1;
        systemResetIn = 1'b0;
        perAddr = 16'h0000;
        perRdEn = 1'b0;
        perWrEn = 1'b0;
        perWrData = 16'h0000;
        rstNmiPin = 1'b1;
        supervisorIrqEnable = 1'b0;
        globalIrqEnable = 1'b0;
        irqServiced = 1'b0;
        flagClear = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        // Reset state and keyless read; an unmapped address reads zero.
        rd(SUPERVISOR_CONTROL_ADDR, rdData);
        `CHECK(rdData, 16'h6900)
        `CHECK(intervalVectorSel, 1'b0)
        rd(16'h0122, rdData);
        `CHECK(rdData, 16'h0000)
        // Interval mode, shortest tap, clear in the same write.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A1B);
        wait_flag(100, n);
        `CHECK(n inside {[62:68]}, 1'b1)
        rd(SUPERVISOR_CONTROL_ADDR, rdData);
        `CHECK(rdData, 16'h6913)
        `CHECK(intervalVectorSel, 1'b1)
        // Interrupt needs flag, enable and global enable together.
        supervisorIrqEnable = 1'b1;
        #1 `CHECK(irqRequest, 1'b0)
        @(posedge core_clk);
        #1 globalIrqEnable = 1'b1;
        #1 `CHECK(irqRequest, 1'b1)
        @(posedge core_clk);
        #1 irqServiced = 1'b1;
        @(posedge core_clk);
        #1 irqServiced = 1'b0;
        `CHECK(supervisorFlag, 1'b0)
        `CHECK(irqRequest, 1'b0)
        // The next period is twice the first tap distance.
        wait_flag(200, n);
        `CHECK(n inside {[115:130]}, 1'b1)
        globalIrqEnable = 1'b0;
        clear_flag();
        // Hold freezes the counter; release resumes from zero.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A9B);
        repeat (150) @(posedge core_clk);
        #1 `CHECK(supervisorFlag, 1'b0)
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A13);
        wait_flag(100, n);
        `CHECK(n inside {[58:68]}, 1'b1)
        clear_flag();
        // The three longer taps, each chosen in the write that clears.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A1A);
        wait_flag(600, n);
        `CHECK(n inside {[508:516]}, 1'b1)
        clear_flag();
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A19);
        wait_flag(8300, n);
        `CHECK(n inside {[8188:8196]}, 1'b1)
        clear_flag();
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A18);
        wait_flag(33000, n);
        `CHECK(n inside {[32764:32772]}, 1'b1)
        clear_flag();
        // Hold set first, clock switched under it, then counting on the aux tick.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A90);
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A9F);
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A1F);
        wait_flag(400, n);
        `CHECK(n inside {[248:266]}, 1'b1)
        clear_flag();
        // A wrong key resets the block and marks the flag.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A93);
        wr(SUPERVISOR_CONTROL_ADDR, 16'h1213);
        wait_reset(3, n);
        `CHECK(systemResetReq, 1'b1)
        `CHECK(supervisorFlag, 1'b1)
        rd(SUPERVISOR_CONTROL_ADDR, rdData);
        `CHECK(rdData, 16'h6900)
        // An outside reset clears control but keeps the flag.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A93);
        @(posedge core_clk);
        #1 systemResetIn = 1'b1;
        @(posedge core_clk);
        #1 systemResetIn = 1'b0;
        rd(SUPERVISOR_CONTROL_ADDR, rdData);
        `CHECK(rdData, 16'h6900)
        `CHECK(supervisorFlag, 1'b1)
        globalIrqEnable = 1'b1;
        #1 `CHECK(irqRequest, 1'b0)
        @(posedge core_clk);
        #1 globalIrqEnable = 1'b0;
        clear_flag();
        // Watchdog expiry on the shortest tap.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5A0B);
        wait_reset(100, n);
        `CHECK(n inside {[62:68]}, 1'b1)
        `CHECK(supervisorFlag, 1'b1)
        rd(SUPERVISOR_CONTROL_ADDR, rdData);
        `CHECK(rdData, 16'h6900)
        // Pin as level reset, then as rising and falling edge interrupt.
        rstNmiPin = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 `CHECK(pinResetActive, 1'b1)
        rstNmiPin = 1'b1;
        repeat (6) @(posedge core_clk);
        #1 `CHECK(pinResetActive, 1'b0)
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5AA0);
        rstNmiPin = 1'b0;
        count_nmi(8, n);
        `CHECK(n, 0)
        `CHECK(pinResetActive, 1'b0)
        rstNmiPin = 1'b1;
        count_nmi(8, n);
        `CHECK(n, 1)
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5AE0);
        repeat (8) @(posedge core_clk);
        #1 rstNmiPin = 1'b0;
        count_nmi(8, n);
        `CHECK(n, 1)
        rstNmiPin = 1'b1;
        count_nmi(8, n);
        `CHECK(n, 0)
        // Flipping the edge select back with the pin steady high looks like an edge.
        wr(SUPERVISOR_CONTROL_ADDR, 16'h5AA0);
        count_nmi(4, n);
        `CHECK(n, 1)
        give_verdict();
    end

endmodule // watch_supervisor_tb
